// >>> pkg/dllg_pkg.sv
// shared constants, register map and carrier types of the delay-locked clock generator
`default_nettype none
package dllg_pkg;
   // width of every cycle counter (period, phase, taps)
   localparam int PW = 16;

   // register byte offsets on the wishbone slave
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_PERIOD = 8'h08;
   localparam logic [7:0] ADR_TAPS = 8'h0C;

   // control register field positions
   localparam int CTRL_LOOP_RST_BIT = 0;
   localparam int CTRL_DUTY_BIT = 1;
   localparam int CTRL_WAIT_BIT = 2;
   localparam int CTRL_DIV_LSB = 3;
   localparam int CTRL_W = 6;
   // duty correction on, no startup wait, divide by 2
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h0A;

   // status register field positions
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_DONE_BIT = 1;

   // timing: system clock and the measurement limits
   localparam int CLOCK_PERIOD_NS = 10;
   localparam logic [PW-1:0] PERIOD_MIN = 16'h0004;
   localparam logic [PW-1:0] LOCK_TOL = 16'h0001;
   localparam logic [11:0] LOCK_PERIODS_DEFAULT = 12'h0800;

   // divide ratio selections
   localparam logic [2:0] DIV_1P5 = 3'h0;
   localparam logic [2:0] DIV_2 = 3'h1;
   localparam logic [2:0] DIV_2P5 = 3'h2;
   localparam logic [2:0] DIV_3 = 3'h3;
   localparam logic [2:0] DIV_4 = 3'h4;
   localparam logic [2:0] DIV_5 = 3'h5;
   localparam logic [2:0] DIV_8 = 3'h6;
   localparam logic [2:0] DIV_16 = 3'h7;

   // control fields as seen by the loop
   typedef struct packed {
      logic [2:0] divSel;
      logic startupWait;
      logic dutyCorrect;
      logic loopReset;
   } dllg_ctrl_t;

   // the generated clock set
   typedef struct packed {
      logic phase0;
      logic phase90;
      logic phase180;
      logic phase270;
      logic doubled;
      logic divided;
   } dllg_clocks_t;

   // loop states
   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_ACQUIRE = 3'b010,
      ST_LOCKED = 3'b100
   } dllg_state_t;

   // quarter periods of the 1x clock per half period of the divided clock
   function automatic logic [5:0] divQuarters(input logic [2:0] sel);
      logic [5:0] q;
      q = 6'h04;
      case (sel)
         DIV_1P5: q = 6'h03;
         DIV_2: q = 6'h04;
         DIV_2P5: q = 6'h05;
         DIV_3: q = 6'h06;
         DIV_4: q = 6'h08;
         DIV_5: q = 6'h0A;
         DIV_8: q = 6'h10;
         DIV_16: q = 6'h20;
         default: q = 6'h04;
      endcase
      return q;
   endfunction
endpackage
`default_nettype wire

// >>> rtl/dllg_sync.sv
// two-flop synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none
module dllg_sync (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic asyncIn,
   output logic syncOut
);
   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   // first flop feeds only the second
   always_comb begin
      meta_next = asyncIn;
      sync_next = meta_reg;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign syncOut = sync_reg;
endmodule
`default_nettype wire

// >>> rtl/dllg_clock_gen.sv
// delay-locked clock generator: measures the source clock, aligns to feedback, builds the clock set
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module dllg_clock_gen #(
   parameter logic [11:0] LOCK_PERIODS = dllg_pkg::LOCK_PERIODS_DEFAULT,
   parameter bit HIGH_FREQ = 1'b0
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sourceClockIn,
   input wire logic feedbackClockIn,
   input wire logic configReadyIn,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAck,
   output logic phase0ClockOut,
   output logic phase90ClockOut,
   output logic phase180ClockOut,
   output logic phase270ClockOut,
   output logic doubledClockOut,
   output logic dividedClockOut,
   output logic lockedOut,
   output logic configDoneOut
);
   localparam int PW = dllg_pkg::PW;

   logic srcSync;
   logic fbSync;
   dllg_pkg::dllg_ctrl_t ctrl_reg;
   dllg_pkg::dllg_ctrl_t ctrl_next;
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic srcPrev_reg;
   logic srcPrev_next;
   logic fbPrev_reg;
   logic fbPrev_next;
   logic [PW-1:0] cnt_reg;
   logic [PW-1:0] cnt_next;
   logic [PW-1:0] period_reg;
   logic [PW-1:0] period_next;
   logic [PW-1:0] high_reg;
   logic [PW-1:0] high_next;
   logic [PW-1:0] ph_reg;
   logic [PW-1:0] ph_next;
   logic [PW-1:0] taps_reg;
   logic [PW-1:0] taps_next;
   logic [PW-1:0] meas_reg;
   logic [PW-1:0] meas_next;
   logic measOn_reg;
   logic measOn_next;
   logic aligned_reg;
   logic aligned_next;
   logic [11:0] good_reg;
   logic [11:0] good_next;
   dllg_pkg::dllg_state_t state_reg;
   dllg_pkg::dllg_state_t state_next;
   dllg_pkg::dllg_clocks_t clk_reg;
   dllg_pkg::dllg_clocks_t clk_next;
   logic [5:0] divCnt_reg;
   logic [5:0] divCnt_next;
   logic divRun_reg;
   logic divRun_next;
   logic done_reg;
   logic done_next;
   logic srcRise;
   logic srcFall;
   logic fbRise;
   logic fbNear;
   logic loopRst;
   logic periodOk;
   logic locked;
   logic [PW-1:0] q1;
   logic [PW-1:0] q2;
   logic [PW-1:0] q3;

   // pins cross into the system clock domain
   dllg_sync srcSyncInst (
      .clock(clock),
      .sys_rst(sys_rst),
      .asyncIn(sourceClockIn),
      .syncOut(srcSync)
   );
   dllg_sync fbSyncInst (
      .clock(clock),
      .sys_rst(sys_rst),
      .asyncIn(feedbackClockIn),
      .syncOut(fbSync)
   );

   // edge events and derived quarter points
   assign srcRise = srcSync & ~srcPrev_reg;
   assign srcFall = ~srcSync & srcPrev_reg;
   assign fbRise = fbSync & ~fbPrev_reg;
   assign fbNear = fbRise & ((cnt_reg <= dllg_pkg::LOCK_TOL) | (cnt_reg + dllg_pkg::LOCK_TOL >= period_reg));
   assign loopRst = ctrl_reg.loopReset;
   assign periodOk = (period_reg >= dllg_pkg::PERIOD_MIN);
   assign locked = (state_reg == dllg_pkg::ST_LOCKED);
   assign q1 = period_reg >> 2;
   assign q2 = period_reg >> 1;
   assign q3 = q1 + q2;

   // phase distance behind an offset, modulo the period
   function automatic logic [PW-1:0] lagOf(input logic [PW-1:0] ph, input logic [PW-1:0] off,
                                          input logic [PW-1:0] per);
      logic [PW-1:0] r;
      r = (ph >= off) ? (ph - off) : (ph + per - off);
      return r;
   endfunction

   // wishbone slave: ack one cycle after the request, writes at the edge that ends the ack cycle
   always_comb begin
      ack_next = wbCyc & wbStb & ~ack_reg;
      ctrl_next = ctrl_reg;
      rdat_next = rdat_reg;
      if (wbCyc && wbStb && !ack_reg) begin
         rdat_next = 32'h0000_0000;
         if (wbAdr == dllg_pkg::ADR_CTRL) begin
            rdat_next[dllg_pkg::CTRL_W-1:0] = ctrl_reg;
         end else if (wbAdr == dllg_pkg::ADR_STATUS) begin
            rdat_next[dllg_pkg::STAT_LOCK_BIT] = locked;
            rdat_next[dllg_pkg::STAT_DONE_BIT] = done_reg;
         end else if (wbAdr == dllg_pkg::ADR_PERIOD) begin
            rdat_next[PW-1:0] = period_reg;
         end else if (wbAdr == dllg_pkg::ADR_TAPS) begin
            rdat_next[PW-1:0] = taps_reg;
         end
      end
      if (wbCyc && wbStb && wbWe && ack_reg && wbSel[0] && wbAdr == dllg_pkg::ADR_CTRL) begin
         ctrl_next = wbDatI[dllg_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
         ctrl_reg <= dllg_pkg::CTRL_RESET;
      end else begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
         ctrl_reg <= ctrl_next;
      end
   end

   assign wbAck = ack_reg;
   assign wbDatO = rdat_reg;

   // source period and high time measurement
   always_comb begin
      srcPrev_next = srcSync;
      fbPrev_next = fbSync;
      cnt_next = (cnt_reg == {PW{1'b1}}) ? cnt_reg : cnt_reg + 16'h0001;
      period_next = period_reg;
      high_next = high_reg;
      if (srcRise) begin
         period_next = cnt_reg + 16'h0001;
         cnt_next = 16'h0000;
      end
      if (srcFall) begin
         high_next = cnt_reg + 16'h0001;
      end
      if (loopRst) begin
         cnt_next = 16'h0000;
         period_next = 16'h0000;
         high_next = 16'h0000;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         srcPrev_reg <= 1'b0;
         fbPrev_reg <= 1'b0;
         cnt_reg <= 16'h0000;
         period_reg <= 16'h0000;
         high_reg <= 16'h0000;
      end else begin
         srcPrev_reg <= srcPrev_next;
         fbPrev_reg <= fbPrev_next;
         cnt_reg <= cnt_next;
         period_reg <= period_next;
         high_reg <= high_next;
      end
   end

   // phase tracking, tap measurement and lock decision
   always_comb begin
      ph_next = (ph_reg + 16'h0001 >= period_reg) ? 16'h0000 : ph_reg + 16'h0001;
      taps_next = taps_reg;
      meas_next = meas_reg + 16'h0001;
      measOn_next = measOn_reg;
      aligned_next = aligned_reg;
      good_next = good_reg;
      state_next = state_reg;
      if (srcRise) begin
         ph_next = (taps_reg < period_reg) ? taps_reg : 16'h0000;
      end
      if (periodOk && ph_reg == 16'h0000) begin
         meas_next = 16'h0000;
         measOn_next = 1'b1;
      end else if (fbRise && measOn_reg) begin
         taps_next = (meas_reg < period_reg) ? meas_reg : 16'h0000;
         measOn_next = 1'b0;
      end
      // feedback edge close to the source edge
      if (fbNear) begin
         aligned_next = 1'b1;
      end
      case (state_reg)
         dllg_pkg::ST_RESET: begin
            state_next = dllg_pkg::ST_ACQUIRE;
         end
         dllg_pkg::ST_ACQUIRE: begin
            if (srcRise) begin
               // a feedback edge in this very cycle still counts
               aligned_next = fbNear;
               if (periodOk && aligned_reg && (cnt_reg + 16'h0001 <= period_reg + dllg_pkg::LOCK_TOL)
                   && (cnt_reg + 16'h0001 + dllg_pkg::LOCK_TOL >= period_reg)) begin
                  good_next = good_reg + 12'h001;
               end else begin
                  good_next = 12'h000;
               end
               if (good_reg >= LOCK_PERIODS) begin
                  state_next = dllg_pkg::ST_LOCKED;
               end
            end
         end
         dllg_pkg::ST_LOCKED: begin
            state_next = dllg_pkg::ST_LOCKED;
         end
         default: begin
            state_next = dllg_pkg::ST_RESET;
         end
      endcase
      // taps and lock cleared at once
      if (loopRst) begin
         ph_next = 16'h0000;
         taps_next = 16'h0000;
         measOn_next = 1'b0;
         aligned_next = 1'b0;
         good_next = 12'h000;
         state_next = dllg_pkg::ST_RESET;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ph_reg <= 16'h0000;
         taps_reg <= 16'h0000;
         meas_reg <= 16'h0000;
         measOn_reg <= 1'b0;
         aligned_reg <= 1'b0;
         good_reg <= 12'h000;
         state_reg <= dllg_pkg::ST_RESET;
      end else begin
         ph_reg <= ph_next;
         taps_reg <= taps_next;
         meas_reg <= meas_next;
         measOn_reg <= measOn_next;
         aligned_reg <= aligned_next;
         good_reg <= good_next;
         state_reg <= state_next;
      end
   end

   // generated clock waveforms from the phase count
   always_comb begin
      logic [PW-1:0] width;
      logic tick;
      width = ctrl_reg.dutyCorrect ? q2 : high_reg;
      tick = (ph_reg == 16'h0000) || (ph_reg == q1) || (ph_reg == q2) || (ph_reg == q3);
      clk_next = '0;
      divCnt_next = divCnt_reg;
      divRun_next = divRun_reg;
      clk_next.phase0 = ph_reg < width;
      clk_next.phase90 = lagOf(ph_reg, q1, period_reg) < width;
      clk_next.phase180 = lagOf(ph_reg, q2, period_reg) < width;
      clk_next.phase270 = lagOf(ph_reg, q3, period_reg) < width;
      clk_next.doubled = locked ? ((ph_reg < q1) || (ph_reg >= q2 && ph_reg < q3)) : (ph_reg < q1);
      clk_next.divided = clk_reg.divided;
      // toggle every N half periods in quarters
      if (!locked) begin
         clk_next.divided = 1'b0;
         divCnt_next = 6'h00;
         divRun_next = 1'b0;
      end else if (tick) begin
         if (!divRun_reg) begin
            if (ph_reg == 16'h0000) begin
               divRun_next = 1'b1;
               clk_next.divided = 1'b1;
               divCnt_next = 6'h01;
            end
         end else if (divCnt_reg >= dllg_pkg::divQuarters(ctrl_reg.divSel)) begin
            clk_next.divided = ~clk_reg.divided;
            divCnt_next = 6'h01;
         end else begin
            divCnt_next = divCnt_reg + 6'h01;
         end
      end
      if (HIGH_FREQ) begin
         clk_next.phase90 = 1'b0;
         clk_next.phase270 = 1'b0;
         clk_next.doubled = 1'b0;
      end
      if (loopRst || !periodOk) begin
         clk_next = '0;
         divCnt_next = 6'h00;
         divRun_next = 1'b0;
      end
   end

   // done held low while waiting for lock
   always_comb begin
      done_next = configReadyIn & (~ctrl_reg.startupWait | locked);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clk_reg <= '0;
         divCnt_reg <= 6'h00;
         divRun_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         clk_reg <= clk_next;
         divCnt_reg <= divCnt_next;
         divRun_reg <= divRun_next;
         done_reg <= done_next;
      end
   end

   // clocks and done registered, locked decoded from the state register
   assign phase0ClockOut = clk_reg.phase0;
   assign phase90ClockOut = clk_reg.phase90;
   assign phase180ClockOut = clk_reg.phase180;
   assign phase270ClockOut = clk_reg.phase270;
   assign doubledClockOut = clk_reg.doubled;
   assign dividedClockOut = clk_reg.divided;
   assign lockedOut = locked;
   assign configDoneOut = done_reg;
endmodule
`default_nettype wire

// >>> bench/dllg_props.sv
// port assertions of the delay-locked clock generator
`timescale 1ns/1ps
`default_nettype none
module dllg_props #(
   parameter logic [11:0] LOCK_PERIODS = 12'h800
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   input wire logic [31:0] wbDatO,
   input wire logic wbAck,
   input wire logic phase0ClockOut,
   input wire logic phase90ClockOut,
   input wire logic phase180ClockOut,
   input wire logic doubledClockOut,
   input wire logic dividedClockOut,
   input wire logic lockedOut,
   input wire logic configDoneOut
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic [15:0] upCnt_reg;
   logic [15:0] upCnt_next;
   // cycles since reset, saturating
   always_comb begin
      upCnt_next = (upCnt_reg == 16'hFFFF) ? upCnt_reg : upCnt_reg + 16'h0001;
      if (sys_rst) upCnt_next = 16'h0000;
   end
   always_ff @(posedge clock) begin
      upCnt_reg <= upCnt_next;
   end
   logic dutyOn_reg;
   logic dutyOn_next;
   // duty correction setting as last written
   always_comb begin
      dutyOn_next = dutyOn_reg;
      if (wbAck && wbWe && wbSel[0] && wbAdr == dllg_pkg::ADR_CTRL) dutyOn_next = wbDatI[dllg_pkg::CTRL_DUTY_BIT];
      if (sys_rst) dutyOn_next = dllg_pkg::CTRL_RESET[dllg_pkg::CTRL_DUTY_BIT];
   end
   always_ff @(posedge clock) begin
      dutyOn_reg <= dutyOn_next;
   end
   property p_ack;
      wbCyc && wbStb && !wbAck |=> wbAck;
   endproperty
   a_ack: assert property (p_ack) else $error("request not answered");
   property p_ackOne;
      wbAck |=> !wbAck;
   endproperty
   a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
   property p_datHold;
      !wbAck && !(wbCyc && wbStb) |=> $stable(wbDatO);
   endproperty
   a_datHold: assert property (p_datHold) else $error("read data moved while idle");
   property p_rst;
      disable iff (1'b0) sys_rst |=> !lockedOut && !configDoneOut && !wbAck;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_loopRst;
      wbAck && wbWe && wbAdr == dllg_pkg::ADR_CTRL && wbSel[0] && wbDatI[0] |-> ##[1:4] !lockedOut;
   endproperty
   a_loopRst: assert property (p_loopRst) else $error("lock held after loop reset");
   property p_dblPre;
      !lockedOut && !$past(lockedOut) && doubledClockOut |-> phase0ClockOut;
   endproperty
   a_dblPre: assert property (p_dblPre) else $error("doubled not quarter pulse");
   property p_dblPost;
      lockedOut && $past(lockedOut, 2) && dutyOn_reg && $past(dutyOn_reg)
         |-> doubledClockOut == (phase0ClockOut ^ phase90ClockOut);
   endproperty
   a_dblPost: assert property (p_dblPost) else $error("doubled not twice rate");
   property p_divPre;
      !lockedOut && !$past(lockedOut) |-> !dividedClockOut;
   endproperty
   a_divPre: assert property (p_divPre) else $error("divided runs unlocked");
   property p_half;
      lockedOut && $past(lockedOut) && dutyOn_reg && $past(dutyOn_reg) |-> phase180ClockOut != phase0ClockOut;
   endproperty
   a_half: assert property (p_half) else $error("half period copy wrong");
   property p_lockLate;
      $rose(lockedOut) |-> upCnt_reg > {2'b00, LOCK_PERIODS, 2'b00};
   endproperty
   a_lockLate: assert property (p_lockLate) else $error("lock too early");
   c_lock: cover property ($rose(lockedOut));
   c_div: cover property ($rose(dividedClockOut));
   c_wr: cover property (wbAck && wbWe);
endmodule
bind dllg_clock_gen dllg_props #(.LOCK_PERIODS(LOCK_PERIODS)) u_props (.clock(clock), .sys_rst(sys_rst),
   .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
   .wbDatO(wbDatO), .wbAck(wbAck), .phase0ClockOut(phase0ClockOut), .phase90ClockOut(phase90ClockOut),
   .phase180ClockOut(phase180ClockOut), .doubledClockOut(doubledClockOut),
   .dividedClockOut(dividedClockOut), .lockedOut(lockedOut), .configDoneOut(configDoneOut));
`default_nettype wire

// >>> bench/dllg_partner.sv
// source oscillator and clock distribution return path
`timescale 1ns/1ps
`default_nettype none
module dllg_partner #(
   parameter int HIGH_NS = 40,
   parameter int LOW_NS = 120,
   parameter int RETURN_NS = 23
) (
   input wire logic phase0ClockOut,
   output logic sourceClockIn,
   output logic feedbackClockIn
);
   // free-running 25/75 source, fixed period
   // period never drifts
   initial begin
      sourceClockIn = 1'b0;
      feedbackClockIn = 1'b0;
      #3;
      forever begin
         sourceClockIn = 1'b1;
         #(HIGH_NS);
         sourceClockIn = 1'b0;
         #(LOW_NS);
      end
   end
   // distribution delay back to feedback
   // only phase zero returns
   always @(phase0ClockOut) begin
      feedbackClockIn <= #(RETURN_NS) phase0ClockOut;
   end
endmodule
`default_nettype wire

// >>> bench/tb_dllg_clock_gen.sv
// self-checking bench for the delay-locked clock generator
`timescale 1ns/1ps
`default_nettype none
module tb_dllg_clock_gen;
   logic clock, sys_rst, srcClk, fbClk, configReadyIn, wbCyc, wbStb, wbWe, wbAck, lockedOut, configDoneOut;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatI, wbDatO, rnd;
   dllg_pkg::dllg_clocks_t clk;
   logic [31:0] expQ[$];
   string nameQ[$];
   int n_errors, checked, n, m, i;
   int halfTab[8] = '{12, 16, 20, 24, 32, 40, 64, 128};
   dllg_clock_gen #(.LOCK_PERIODS(12'h004), .HIGH_FREQ(1'b0)) u_dut (.clock(clock), .sys_rst(sys_rst),
      .sourceClockIn(srcClk), .feedbackClockIn(fbClk), .configReadyIn(configReadyIn), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
      .wbAck(wbAck), .phase0ClockOut(clk.phase0), .phase90ClockOut(clk.phase90),
      .phase180ClockOut(clk.phase180), .phase270ClockOut(clk.phase270), .doubledClockOut(clk.doubled),
      .dividedClockOut(clk.divided), .lockedOut(lockedOut), .configDoneOut(configDoneOut));
   dllg_partner u_src (.phase0ClockOut(clk.phase0), .sourceClockIn(srcClk), .feedbackClockIn(fbClk));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic sig(input int k);
      return clk[5-k];
   endfunction
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
      checked++;
      if (got !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one classic cycle, held until ack
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= d;
      do begin
         @(posedge clock);
         k++;
      end while (wbAck !== 1'b1 && k < 20);
      if (k >= 20) n_errors++;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      nameQ.push_back($sformatf("reg %h", a));
      xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic lvl(input int k, input logic v, output int c);
      c = 0;
      do begin
         @(negedge clock);
         c++;
      end while (sig(k) !== v && c < 400);
   endtask
   task automatic waitLock(input bit holdDone);
      int c;
      c = 0;
      while (lockedOut !== 1'b1 && c < 2000) begin
         @(negedge clock);
         c++;
         if (holdDone && lockedOut !== 1'b1) check("done early", 32'h0, {31'h0, configDoneOut});
      end
      check("locked", 32'h1, {31'h0, lockedOut});
   endtask
   // read answers against oldest note
   always @(posedge clock) begin
      if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) check(nameQ.pop_front(), expQ.pop_front(), wbDatO);
   end
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      end_of_test();
   end
   initial begin
      {wbCyc, wbStb, wbWe, wbAdr, wbDatI} = '0;
      wbSel = 4'hF;
      // config logic not ready until startup wait is set
      configReadyIn = 1'b0;
      rnd = 32'h0e38_a322;
      sys_rst = 1'b1;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0000_000A);
      rd(8'h04, 32'h0000_0000);
      xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
      rd(8'h10, 32'h0000_0000);
      $display("regs done");
      xfer(1'b1, 8'h00, 32'h0000_000E);
      configReadyIn <= 1'b1;
      waitLock(1'b1);
      repeat (3) @(posedge clock);
      rd(8'h04, 32'h0000_0003);
      $display("startup wait done");
      for (i = 1; i < 4; i++) begin
         lvl(0, 1'b0, n);
         lvl(0, 1'b1, n);
         // the lagging copy may still be high from the last period
         lvl(i, 1'b0, m);
         lvl(i, 1'b1, n);
         check($sformatf("lag %0d", i), 32'(4 * i), 32'(m + n));
      end
      lvl(0, 1'b1, n);
      lvl(0, 1'b0, n);
      check("phase0 high", 32'd8, 32'(n));
      lvl(0, 1'b1, n);
      check("phase0 low", 32'd8, 32'(n));
      // duty correction off copies the 25/75 source
      xfer(1'b1, 8'h00, 32'h0000_0008);
      lvl(0, 1'b0, n);
      lvl(0, 1'b1, n);
      lvl(0, 1'b0, n);
      check("phase0 high raw", 32'd4, 32'(n));
      lvl(0, 1'b1, n);
      check("phase0 low raw", 32'd12, 32'(n));
      $display("phases done");
      rnd = xs(rnd);
      for (i = 0; i < 8; i++) begin
         n = (int'(rnd[2:0]) + i) % 8;
         xfer(1'b1, 8'h00, 32'(n * 8 + 2));
         lvl(5, 1'b0, n);
         lvl(5, 1'b1, n);
         lvl(5, 1'b0, n);
         check("div high", 32'(halfTab[(int'(rnd[2:0]) + i) % 8]), 32'(n));
         lvl(5, 1'b1, n);
         check("div low", 32'(halfTab[(int'(rnd[2:0]) + i) % 8]), 32'(n));
      end
      $display("divider done");
      xfer(1'b1, 8'h00, 32'h0000_000B);
      repeat (2) @(negedge clock);
      check("lock after loop reset", 32'h0, {31'h0, lockedOut});
      rd(8'h0C, 32'h0000_0000);
      rd(8'h08, 32'h0000_0000);
      xfer(1'b1, 8'h00, 32'h0000_000A);
      waitLock(1'b0);
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0000_000A);
      $display("loop reset done");
      // let the last read answer be compared first
      repeat (2) @(posedge clock);
      end_of_test();
   end
endmodule
`default_nettype wire
